// >>> logic/adr_div.sv
// Purpose: sequential restoring divider, one quotient bit per cycle
// Assumes: start is a one-cycle pulse while idle
// Notes:   divisor zero gives all ones; latency DW+1 cycles
`timescale 1ns/1ps
module adr_div #(
  parameter int unsigned DW = 48,
  parameter int unsigned VW = 32
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // request
  input wire logic start,
  input wire logic [DW-1:0] dividend,
  input wire logic [VW-1:0] divisor,
  // answer
  output logic done,
  output logic [DW-1:0] quotient
);

  typedef struct packed {
    logic [VW:0] rem;
    logic [DW-1:0] quo;
    logic [VW-1:0] dvs;
    logic [7:0] cnt;
    logic run;
    logic done;
  } adr_div_st_s;

  adr_div_st_s st, next_st;

  // ---------------------------------------------------------------
  // shift and subtract
  // ---------------------------------------------------------------
  always_comb begin
    logic [VW:0] sh;
    sh = {st.rem[VW-1:0], st.quo[DW-1]};
    next_st = st;
    next_st.done = 1'b0;
    if (start && !st.run) begin
      next_st.rem = '0;
      next_st.quo = dividend;
      next_st.dvs = divisor;
      next_st.cnt = 8'(DW);
      next_st.run = 1'b1;
    end else if (st.run) begin
      if (sh >= {1'b0, st.dvs}) begin
        next_st.rem = sh - {1'b0, st.dvs};
        next_st.quo = {st.quo[DW-2:0], 1'b1};
      end else begin
        next_st.rem = sh;
        next_st.quo = {st.quo[DW-2:0], 1'b0};
      end
      next_st.cnt = st.cnt - 8'h01;
      if (st.cnt == 8'h01) begin
        next_st.run = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign done = st.done;
  assign quotient = st.quo;

endmodule // adr_div

// >>> logic/adr_ramp.sv
// Purpose: output-frequency ramp generator with register file
// Assumes: Avalon-MM slave, byte addresses, one waitrequest cycle
// Notes:   S-pattern shapes run as linear slopes, B of the same duration, A timed against base
`timescale 1ns/1ps
// Notes on behaviour
// - Rising from 0 Hz to the reference takes the accel time, 0..3600 s.
// - Falling from the reference to 0 Hz takes the decel time, 0..3600 s.
// - The reference frequency is settable 1..400 Hz, 50 Hz after reset.
// - With the second set selected the alternate times replace the main.
// - The alternate accel time also governs decel unless one is set.
// - An alternate decel time of 9999 means use the alternate accel time.
// - Only a terminal whose function code is 3 drives the second set.
// - Under S-pattern A the time setting refers to the base frequency.
// - Under S-pattern A above base, time is 4/9 T (f/fb)^2 plus 5/9 T.
// - Any time setting of 0.03 s or less runs as 0.04 s.
// - Writing the reference leaves both gain settings untouched.
// - The second set select also enables all other second functions.
// - Reference and alternate times write only when ext display is 0.
// - Shape codes are 0 linear, 1 S-pattern A, 2 S-pattern B.
module adr_ramp #(
  parameter int unsigned TICK_CYCLES = adr_pkg::TICK_CYC,
  parameter int unsigned NTERM = 5
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // external terminals
  input wire logic [NTERM-1:0] terminal_in,
  // drive output stage
  output logic [15:0] out_freq,
  output logic second_func_en,
  output logic ramping
);

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [1:0] shape;
    logic [7:0] ext;
    logic [15:0] ref_f;
    logic [15:0] base_f;
    logic [15:0] tgt;
    logic [15:0] gain_a;
    logic [15:0] gain_b;
    logic [18:0] acc_t;
    logic [18:0] dec_t;
    logic [18:0] alt_a;
    logic [18:0] alt_d;
    logic [NTERM*adr_pkg::TSEL_W-1:0] tsel;
    logic second;
    adr_pkg::adr_calc_e fsm;
    logic [18:0] tm;
    logic [15:0] num;
    logic [31:0] step;
    logic [31:0] fout;
    logic [18:0] tick;
    logic ramping;
    logic dstart;
    logic [47:0] dvd;
    logic [31:0] dvs;
  } adr_ramp_st_s;

  adr_ramp_st_s st, next_st;
  adr_pkg::adr_avs_req_s req;
  logic [1:0] rst_q;
  logic rst_n;
  logic [NTERM-1:0] term_s;
  logic div_done;
  logic [47:0] div_q;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // main or alternate pair, 9999 falls back to alternate accel
  function automatic logic [18:0] pick_time(
    input logic sec, input logic up,
    input logic [18:0] a, input logic [18:0] d,
    input logic [18:0] aa, input logic [18:0] ad);
    if (!sec) begin
      pick_time = up ? a : d;
    end else if (up || ad == adr_pkg::TIME_SENT) begin
      pick_time = aa;
    end else begin
      pick_time = ad;
    end
  endfunction

  // very short settings would give absurd slopes
  function automatic logic [18:0] clamp_min(input logic [18:0] t);
    if (t <= adr_pkg::TIME_MIN_IN) begin
      clamp_min = adr_pkg::TIME_MIN_RUN;
    end else begin
      clamp_min = t;
    end
  endfunction

  function automatic logic [31:0] be_merge(
    input logic [31:0] old, input logic [31:0] wd,
    input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic [31:0] sat32(input logic [47:0] q);
    if (|q[47:32]) begin
      sat32 = 32'hffff_ffff;
    end else if (q[31:0] == 32'h0) begin
      sat32 = 32'h0000_0001;
    end else begin
      sat32 = q[31:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  // reset release is not frozen by ce so a stopped block still resets
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  adr_sync #(.W(NTERM)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(terminal_in),
    .q(term_s)
  );

  adr_div #(.DW(48), .VW(32)) u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(st.dstart),
    .dividend(st.dvd),
    .divisor(st.dvs),
    .done(div_done),
    .quotient(div_q)
  );

  assign req = '{read: avs_read, write: avs_write,
                 address: avs_address, writedata: avs_writedata,
                 byteenable: avs_byteenable};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    logic up;
    logic [18:0] t;
    logic [15:0] fhi;
    logic [19:0] r;
    logic [47:0] p;
    logic [32:0] sum;
    logic sec;
    w = '0;
    up = st.tgt > st.fout[31:16];
    t = '0;
    fhi = (st.tgt > st.fout[31:16]) ? st.tgt : st.fout[31:16];
    r = '0;
    p = '0;
    sum = '0;
    sec = 1'b0;
    next_st = st;
    next_st.dstart = 1'b0;

    // bus: one wait cycle, then answer with registered data
    next_st.waitreq = !((req.read || req.write) && st.waitreq);
    if (req.read && st.waitreq) begin
      unique case (req.address)
        adr_pkg::OFS_CTRL: next_st.rdata = {16'h0, st.ext, 6'h0,
                                            st.shape};
        adr_pkg::OFS_REF: next_st.rdata = {16'h0, st.ref_f};
        adr_pkg::OFS_BASE: next_st.rdata = {16'h0, st.base_f};
        adr_pkg::OFS_ACC: next_st.rdata = {13'h0, st.acc_t};
        adr_pkg::OFS_DEC: next_st.rdata = {13'h0, st.dec_t};
        adr_pkg::OFS_ALT_ACC: next_st.rdata = {13'h0, st.alt_a};
        adr_pkg::OFS_ALT_DEC: next_st.rdata = {13'h0, st.alt_d};
        adr_pkg::OFS_TSEL: next_st.rdata = 32'(st.tsel);
        adr_pkg::OFS_TGT: next_st.rdata = {16'h0, st.tgt};
        adr_pkg::OFS_GAIN_A: next_st.rdata = {16'h0, st.gain_a};
        adr_pkg::OFS_GAIN_B: next_st.rdata = {16'h0, st.gain_b};
        adr_pkg::OFS_STAT: next_st.rdata = {14'h0, st.ramping,
                                            st.second, st.fout[31:16]};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // write commits at the edge where waitrequest is seen low
    if (req.write && !st.waitreq) begin
      unique case (req.address)
        adr_pkg::OFS_CTRL: begin
          w = be_merge({16'h0, st.ext, 6'h0, st.shape},
                       req.writedata, req.byteenable);
          if (w[1:0] <= adr_pkg::SHAPE_SB) begin
            next_st.shape = w[1:0];
          end
          next_st.ext = w[adr_pkg::CTRL_EXT_LSB +: 8];
        end
        adr_pkg::OFS_REF: begin
          // gains are left as they are on purpose
          w = be_merge({16'h0, st.ref_f}, req.writedata,
                       req.byteenable);
          if (st.ext == 8'h00 && w[31:16] == 16'h0 &&
              w[15:0] >= adr_pkg::REF_MIN &&
              w[15:0] <= adr_pkg::REF_MAX) begin
            next_st.ref_f = w[15:0];
          end
        end
        adr_pkg::OFS_BASE: begin
          w = be_merge({16'h0, st.base_f}, req.writedata,
                       req.byteenable);
          if (w[15:0] != 16'h0) begin
            next_st.base_f = w[15:0];
          end
        end
        adr_pkg::OFS_ACC: begin
          w = be_merge({13'h0, st.acc_t}, req.writedata,
                       req.byteenable);
          if (w <= 32'(adr_pkg::TIME_MAX)) begin
            next_st.acc_t = w[18:0];
          end
        end
        adr_pkg::OFS_DEC: begin
          w = be_merge({13'h0, st.dec_t}, req.writedata,
                       req.byteenable);
          if (w <= 32'(adr_pkg::TIME_MAX)) begin
            next_st.dec_t = w[18:0];
          end
        end
        adr_pkg::OFS_ALT_ACC: begin
          w = be_merge({13'h0, st.alt_a}, req.writedata,
                       req.byteenable);
          if (st.ext == 8'h00 && w <= 32'(adr_pkg::TIME_MAX)) begin
            next_st.alt_a = w[18:0];
          end
        end
        adr_pkg::OFS_ALT_DEC: begin
          w = be_merge({13'h0, st.alt_d}, req.writedata,
                       req.byteenable);
          if (st.ext == 8'h00 && w <= 32'(adr_pkg::TIME_MAX)) begin
            next_st.alt_d = w[18:0];
          end
        end
        adr_pkg::OFS_TSEL: begin
          w = be_merge(32'(st.tsel), req.writedata, req.byteenable);
          next_st.tsel = w[NTERM*adr_pkg::TSEL_W-1:0];
        end
        adr_pkg::OFS_TGT: begin
          w = be_merge({16'h0, st.tgt}, req.writedata,
                       req.byteenable);
          next_st.tgt = w[15:0];
        end
        adr_pkg::OFS_GAIN_A: begin
          w = be_merge({16'h0, st.gain_a}, req.writedata,
                       req.byteenable);
          next_st.gain_a = w[15:0];
        end
        adr_pkg::OFS_GAIN_B: begin
          w = be_merge({16'h0, st.gain_b}, req.writedata,
                       req.byteenable);
          next_st.gain_b = w[15:0];
        end
        default: ;
      endcase
    end

    // second set: only terminals assigned code 3 count
    for (int i = 0; i < NTERM; i++) begin
      if (st.tsel[i*adr_pkg::TSEL_W +: adr_pkg::TSEL_W] ==
          adr_pkg::FN_SECOND && term_s[i]) begin
        sec = 1'b1;
      end
    end
    next_st.second = sec;

    // slope calculation, rerun continuously so edits take effect
    unique case (st.fsm)
      adr_pkg::ST_PREP: begin
        t = clamp_min(pick_time(st.second, up, st.acc_t, st.dec_t,
                                st.alt_a, st.alt_d));
        next_st.tm = t;
        next_st.dstart = 1'b1;
        if (st.shape == adr_pkg::SHAPE_SA &&
            fhi >= st.base_f) begin
          next_st.num = fhi;
          next_st.dvd = {8'h0, 32'(fhi) * 32'(fhi), 8'h00};
          next_st.dvs = 32'(st.base_f) * 32'(st.base_f);
          next_st.fsm = adr_pkg::ST_RATIO;
        end else begin
          // S-pattern A below base runs toward base in time T
          next_st.num = (st.shape == adr_pkg::SHAPE_SA) ?
                        st.base_f : st.ref_f;
          next_st.dvd = {16'h0, next_st.num, 16'h0};
          next_st.dvs = {13'h0, t};
          next_st.fsm = adr_pkg::ST_STEP;
        end
      end
      adr_pkg::ST_RATIO: begin
        if (div_done) begin
          // ratio squared in 8 fractional bits, saturated
          r = (|div_q[47:20]) ? 20'hfffff : div_q[19:0];
          p = 48'({29'h0, st.tm} * {28'h0, r});
          next_st.dvd = (p >> 6) + 48'({29'h0, st.tm} * 48'h5);
          next_st.dvs = 32'h0000_0009;
          next_st.dstart = 1'b1;
          next_st.fsm = adr_pkg::ST_TIME;
        end
      end
      adr_pkg::ST_TIME: begin
        if (div_done) begin
          next_st.dvd = {16'h0, st.num, 16'h0};
          next_st.dvs = sat32(div_q);
          next_st.dstart = 1'b1;
          next_st.fsm = adr_pkg::ST_STEP;
        end
      end
      adr_pkg::ST_STEP: begin
        if (div_done) begin
          next_st.step = sat32(div_q);
          next_st.fsm = adr_pkg::ST_PREP;
        end
      end
    endcase

    // ramp tick every 0.01 s, clamped at the target
    if (st.tick == 19'(TICK_CYCLES - 1)) begin
      next_st.tick = 19'h0;
      if (up) begin
        sum = {1'b0, st.fout} + {1'b0, st.step};
        if (sum[32:16] >= {1'b0, st.tgt}) begin
          next_st.fout = {st.tgt, 16'h0};
        end else begin
          next_st.fout = sum[31:0];
        end
      end else begin
        sum = {1'b0, st.tgt, 16'h0} + {1'b0, st.step};
        if ({1'b0, st.fout} <= sum) begin
          next_st.fout = {st.tgt, 16'h0};
        end else begin
          next_st.fout = st.fout - st.step;
        end
      end
    end else begin
      next_st.tick = st.tick + 19'h1;
    end
    next_st.ramping = next_st.fout != {st.tgt, 16'h0};
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.waitreq <= 1'b1;
      st.ref_f <= adr_pkg::REF_RST;
      st.base_f <= adr_pkg::BASE_RST;
      st.gain_a <= adr_pkg::GAIN_RST;
      st.gain_b <= adr_pkg::GAIN_RST;
      st.acc_t <= adr_pkg::TIME_RST;
      st.dec_t <= adr_pkg::TIME_RST;
      st.alt_a <= adr_pkg::TIME_RST;
      st.alt_d <= adr_pkg::TIME_SENT;
      st.step <= 32'h0000_0001;
      st.fsm <= adr_pkg::ST_PREP;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign out_freq = st.fout[31:16];
  assign second_func_en = st.second;
  assign ramping = st.ramping;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ref_write;
    ce && req.write && !st.waitreq && req.address == adr_pkg::OFS_REF;
  endsequence

  AST_REF_RANGE: assert property (
    st.ref_f >= adr_pkg::REF_MIN && st.ref_f <= adr_pkg::REF_MAX)
    else $error("reference frequency out of range");
  AST_REF_LOCK: assert property (
    s_ref_write ##0 (st.ext != 8'h00) |=> $stable(st.ref_f))
    else $error("reference written while locked");
  AST_GAIN_KEEP: assert property (
    s_ref_write |=> $stable(st.gain_a) && $stable(st.gain_b))
    else $error("gain changed by reference write");
  AST_MIN_TIME: assert property (
    ce && st.fsm == adr_pkg::ST_PREP |=> st.tm >= adr_pkg::TIME_MIN_RUN)
    else $error("ramp time below minimum");
  AST_ALT_DECEL: assert property (
    ce && st.fsm == adr_pkg::ST_PREP && st.second &&
    st.tgt < st.fout[31:16] && st.alt_d == adr_pkg::TIME_SENT &&
    st.alt_a > adr_pkg::TIME_MIN_IN |=> st.tm == $past(st.alt_a))
    else $error("sentinel did not select alternate accel");
  AST_MAIN_ACC: assert property (
    ce && st.fsm == adr_pkg::ST_PREP && !st.second &&
    st.tgt > st.fout[31:16] && st.acc_t > adr_pkg::TIME_MIN_IN
    |=> st.tm == $past(st.acc_t))
    else $error("main accel time not used");
  AST_TERM_CODE: assert property (
    ce && st.tsel == '0 |=> !st.second)
    else $error("second set without code 3 terminal");
  AST_SA_BASE: assert property (
    ce && st.fsm == adr_pkg::ST_PREP && st.shape == adr_pkg::SHAPE_SA &&
    st.tgt < st.base_f && st.fout[31:16] < st.base_f
    |=> st.num == $past(st.base_f))
    else $error("s-pattern a not referred to base");
  AST_NO_OVERSHOOT: assert property (
    ce && st.tgt > st.fout[31:16] && !(req.write && !st.waitreq)
    |=> st.fout[31:16] <= $past(st.tgt))
    else $error("output passed target");
  AST_BUS_ANSWER: assert property (
    ce && (req.read || req.write) && st.waitreq |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule // adr_ramp

// >>> logic/adr_sync.sv
// Purpose: two-flop synchroniser for terminal pins
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module adr_sync #(
  parameter int unsigned W = 5
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // pins in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } adr_sync_st_s;

  adr_sync_st_s st, next_st;

  // ---------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // state register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule // adr_sync

// >>> shared/adr_pkg.sv
// Purpose: shared constants and types for the accel/decel ramp block
// Assumes: 50 MHz ref_clk; times in 0.01 s, frequencies in 0.01 Hz
// Notes:   register offsets are byte addresses on the Avalon-MM slave
package adr_pkg;

  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_US = 10_000; // one ramp tick = 0.01 s
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_REF = 6'h04;
  localparam logic [5:0] OFS_BASE = 6'h08;
  localparam logic [5:0] OFS_ACC = 6'h0c;
  localparam logic [5:0] OFS_DEC = 6'h10;
  localparam logic [5:0] OFS_ALT_ACC = 6'h14;
  localparam logic [5:0] OFS_ALT_DEC = 6'h18;
  localparam logic [5:0] OFS_TSEL = 6'h1c;
  localparam logic [5:0] OFS_TGT = 6'h20;
  localparam logic [5:0] OFS_GAIN_A = 6'h24;
  localparam logic [5:0] OFS_GAIN_B = 6'h28;
  localparam logic [5:0] OFS_STAT = 6'h2c;

  // ---------------------------------------------------------------
  // field positions, limits and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_EXT_LSB = 8;
  localparam int unsigned TSEL_W = 4;
  localparam logic [18:0] TIME_MAX = 19'h57e40; // 3600 s
  localparam logic [18:0] TIME_MIN_IN = 19'h00003; // 0.03 s
  localparam logic [18:0] TIME_MIN_RUN = 19'h00004; // 0.04 s
  localparam logic [18:0] TIME_SENT = 19'h0270f; // 9999
  localparam logic [18:0] TIME_RST = 19'h001f4; // 5 s
  localparam logic [15:0] REF_MIN = 16'h0064; // 1 Hz
  localparam logic [15:0] REF_MAX = 16'h9c40; // 400 Hz
  localparam logic [15:0] REF_RST = 16'h1388; // 50 Hz
  localparam logic [15:0] BASE_RST = 16'h1388;
  localparam logic [15:0] GAIN_RST = 16'h1388;
  localparam logic [3:0] FN_SECOND = 4'h3;
  localparam logic [1:0] SHAPE_LIN = 2'h0;
  localparam logic [1:0] SHAPE_SA = 2'h1;
  localparam logic [1:0] SHAPE_SB = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_PREP, ST_RATIO, ST_TIME, ST_STEP
  } adr_calc_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } adr_avs_req_s;

endpackage

// >>> verification/adr_drive_model.sv
// Purpose: drive stage and terminal pins facing the ramp block
// Assumes: one ref_clk domain, pins are plain levels
// Notes:   steps counts output updates since the last clr
`timescale 1ns/1ps
module adr_drive_model (
  // clock and control
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic set2_on,
  // block side
  input wire logic [15:0] out_freq,
  output logic [4:0] terminal_in,
  output logic [15:0] steps
);
  logic [15:0] last;
  // only terminal 0 carries the second-set line, others held low
  always_comb terminal_in = {4'h0, set2_on};
  // count every frequency step the output stage receives
  always_ff @(posedge ref_clk) begin
    last <= out_freq;
    steps <= clr ? 16'h0 : steps + 16'(out_freq != last);
  end
endmodule // adr_drive_model

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the ramp block
// Assumes: tick shortened to 200 clocks
// Notes:   ramp length is judged by counting output steps
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic clr = 1'b0;
  logic set2 = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic wreq, sec, rmp;
  logic [15:0] fq, steps;
  logic [4:0] term;
  int fails = 0;
  int total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  adr_ramp #(.TICK_CYCLES(200)) dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .ce(1'b1), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .terminal_in(term), .out_freq(fq),
    .second_func_en(sec), .ramping(rmp));
  adr_drive_model drv_u (.ref_clk(ref_clk), .clr(clr), .set2_on(set2),
    .out_freq(fq), .terminal_in(term), .steps(steps));
  // verdict and stop, also reached by any timeout
  task automatic end_sim;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one avalon access; raised after a rising edge, held until the
  // rising edge at which waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      end_sim();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // start a ramp to t and wait, bounded, until the output lands
  task automatic ramp(input logic [15:0] t);
    int n;
    n = 0;
    repeat (400) @(posedge ref_clk); // slope recompute settles
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    bus(1'b1, 6'h20, {16'h0, t});
    repeat (2) @(negedge ref_clk);
    chk("ramping", 32'h1, {31'h0, rmp});
    do begin
      @(negedge ref_clk);
      n++;
    end while (fq !== t && n < 20000);
    if (n >= 20000) begin
      fails++;
      end_sim();
    end
    repeat (2) @(negedge ref_clk);
    chk("landed", 32'h0, {31'h0, rmp});
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, 6'h04, 32'h0);
    chk("ref", 32'h1388, q);
    bus(1'b0, 6'h18, 32'h0);
    chk("alt_dec", 32'h270f, q);
    bus(1'b0, 6'h30, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, 6'h04, 32'h2710);
    bus(1'b0, 6'h24, 32'h0);
    chk("gain_a", 32'h1388, q);
    bus(1'b0, 6'h28, 32'h0);
    chk("gain_b", 32'h1388, q);
    bus(1'b1, 6'h00, 32'h100);
    bus(1'b1, 6'h04, 32'hbb8);
    bus(1'b1, 6'h00, 32'h0);
    bus(1'b0, 6'h04, 32'h0);
    chk("ref_lock", 32'h2710, q);
    $display("test registers done");
    set2 <= 1'b1;
    bus(1'b1, 6'h1c, 32'h2);
    repeat (5) @(negedge ref_clk);
    chk("sec_off", 32'h0, {31'h0, sec});
    bus(1'b1, 6'h1c, 32'h3);
    repeat (5) @(negedge ref_clk);
    chk("sec_on", 32'h1, {31'h0, sec});
    $display("test terminals done");
    @(posedge ref_clk);
    set2 <= 1'b0;
    bus(1'b1, 6'h04, 32'h1388);
    bus(1'b1, 6'h0c, 32'h1); // too short, runs as four ticks
    // equal times both ways, so a slope still held from before the
    // target write gives the same step
    bus(1'b1, 6'h10, 32'h1);
    ramp(16'h1388);
    chk("acc_steps", 32'h4, {16'h0, steps});
    bus(1'b0, 6'h2c, 32'h0);
    chk("status", 32'h1388, q);
    set2 <= 1'b1;
    bus(1'b1, 6'h14, 32'h8);
    ramp(16'h0);
    chk("dec_steps", 32'h8, {16'h0, steps});
    $display("test ramps done");
    // base 49 Hz, target twice base: 6 runs as 14 ticks, and the
    // held decel slope of 4900 over 7 matches 9800 over 14
    @(posedge ref_clk);
    set2 <= 1'b0;
    bus(1'b1, 6'h08, 32'h1324);
    bus(1'b1, 6'h0c, 32'h6);
    bus(1'b1, 6'h10, 32'h7);
    bus(1'b1, 6'h00, 32'h1);
    ramp(16'h2648);
    chk("sa_steps", 32'he, {16'h0, steps});
    $display("test s-pattern done");
    end_sim();
  end
endmodule // tb_top
